// >>> shared/octal_dac_pkg.sv
// Constants and types for the octal converter pin control block.
// Assumes a single 50 MHz clock domain and 14-bit channel codes.
package octal_dac_pkg;
    localparam int          CHANNELS      = 8;
    localparam int          GROUP_SIZE    = 4;
    localparam int          CODE_WIDTH    = 14;
    localparam int          CHAN_BITS     = 3;
    localparam int          MON_WIDTH     = 5;
    // Monitor register encodings
    localparam logic [4:0]  MON_HIGH_Z    = 5'h00;
    localparam logic [4:0]  MON_CHAN_BASE = 5'h10;
    localparam logic [4:0]  MON_REF_A     = 5'h08;
    localparam logic [4:0]  MON_REF_B     = 5'h09;
    localparam logic [4:0]  MON_OFS_A     = 5'h0A;
    localparam logic [4:0]  MON_OFS_B     = 5'h0B;
    // Reset codes chosen by the reset-value select input, then the sign flip and correction cycles
    localparam logic [13:0] RESET_ZERO    = 14'h0000;
    localparam logic [13:0] RESET_MID     = 14'h2000;
    localparam logic [13:0] SIGN_FLIP     = 14'h2000;
    localparam int          CORR_CYCLES   = 4;

    typedef enum logic [2:0] {
        MSRC_NONE,
        MSRC_CHAN,
        MSRC_REF,
        MSRC_OFS
    } mon_src_t;

    typedef enum logic {
        ENG_IDLE,
        ENG_RUN
    } eng_state_t;
endpackage : octal_dac_pkg

// >>> hw/code_bank.sv
// Eight-entry code memory with registered read port.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ps
`default_nettype none
module code_bank
    import octal_dac_pkg::*;
#(
    parameter int WIDTH = CODE_WIDTH,
    parameter int DEPTH = CHANNELS
) (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         clearAll,
    input  wire logic [WIDTH-1:0]             clearValue,
    input  wire logic                         writeEn,
    input  wire logic [$clog2(DEPTH)-1:0]     writeAddr,
    input  wire logic [WIDTH-1:0]             writeData,
    input  wire logic [$clog2(DEPTH)-1:0]     readAddr,
    output var  logic [WIDTH-1:0]             readData
);
    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [WIDTH-1:0] next_readData;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            next_mem[i] = mem[i];
            if (clearAll) begin
                next_mem[i] = clearValue;
            end else if (writeEn && writeAddr == i[$clog2(DEPTH)-1:0]) begin
                next_mem[i] = writeData;
            end
        end
        next_readData = mem[readAddr];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            readData <= '0;
        end else begin
            mem      <= next_mem;
            readData <= next_readData;
        end
    end
endmodule : code_bank
`default_nettype wire

// >>> hw/octal_dac_pin_control.sv
// Pin control of an octal 14-bit converter: format, busy, clear, latch, monitor.
// Assumes a host writing words on the same clock; pins are synchronised here.
// Operation
// - Channel data: straight binary or two's complement
// - Command words always read as straight binary
// - Busy held low while correction runs
// - Busy open-drain, drives low only, pullup
// - Clear low grounds every output via resistor
// - Clear high, latch low: amplifiers drive outputs
// - Monitor: high-Z or exactly one source
// - Channels 0-3 form group A
// - Channels 4-7 form group B
// - Latch low: transparent, data copied to output
// - Reset low restores selected reset values
`timescale 1ns/1ps
`default_nettype none
module octal_dac_pin_control
    import octal_dac_pkg::*;
#(
    parameter int NCHAN = CHANNELS,
    parameter int WIDTH = CODE_WIDTH
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 data_format_select,
    input  wire logic                 clear_outputs_n,
    input  wire logic                 latch_load_n,
    input  wire logic                 reset_value_select,
    input  wire logic                 dataWrite,
    input  wire logic [CHAN_BITS-1:0] dataChannel,
    input  wire logic [WIDTH-1:0]     dataWord,
    input  wire logic                 commandWrite,
    input  wire logic [WIDTH-1:0]     commandWord,
    input  wire logic                 monitorWrite,
    input  wire logic [MON_WIDTH-1:0] monitorWord,
    output var  logic [WIDTH-1:0]     dacCode [NCHAN],
    output var  logic [NCHAN-1:0]     outputGrounded,
    output var  logic [NCHAN-1:0]     outputDriven,
    output var  logic [1:0]           groupOffsetSel,
    output var  logic                 busyOut,
    output var  logic                 busyOe_b,
    output var  logic [WIDTH-1:0]     commandValue,
    output var  logic [MON_WIDTH-1:0] monitorReg,
    output var  logic                 monitorEnable,
    output var  mon_src_t             monitorSource,
    output var  logic [CHAN_BITS-1:0] monitorChannel,
    output var  logic                 monitorGroupB
);
    // Two-flop synchronisers for the level pins
    logic [3:0] pinMeta;
    logic [3:0] pinSync;
    logic       fmtTwos;
    logic       clearLow;
    logic       latchLow;
    logic       rstSelMid;
    assign fmtTwos   = pinSync[0];
    assign clearLow  = ~pinSync[1];
    assign latchLow  = ~pinSync[2];
    assign rstSelMid = pinSync[3];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinMeta <= 4'hE;
            pinSync <= 4'hE;
        end else begin
            pinMeta <= {reset_value_select, latch_load_n, clear_outputs_n, data_format_select};
            pinSync <= pinMeta;
        end
    end

    // Reset code is caught after release, from the synchronised select
    // Load spans both synchroniser stages, so the last load sees the real select
    logic [2:0]       resetHold;
    logic [2:0]       next_resetHold;
    logic             resetPending;
    assign resetPending = resetHold[2];
    logic [WIDTH-1:0] resetCode;
    assign resetCode = rstSelMid ? RESET_MID : RESET_ZERO;

    // Incoming data converted to an internal straight-binary code
    logic [WIDTH-1:0] dataBinary;
    always_comb begin
        dataBinary = dataWord;
        if (fmtTwos) begin
            dataBinary = dataWord ^ SIGN_FLIP;
        end
    end

    // Input registers live in the small memory; the read port scans channels
    logic [CHAN_BITS-1:0] scanIdx;
    logic [CHAN_BITS-1:0] next_scanIdx;
    logic [CHAN_BITS-1:0] scanIdxQ;
    logic [WIDTH-1:0]     scanData;

    code_bank #(
        .WIDTH(WIDTH),
        .DEPTH(NCHAN)
    ) u_bank (
        .clk        (clk),
        .rst_b      (rst_b),
        .clearAll   (resetPending),
        .clearValue (resetCode),
        .writeEn    (dataWrite),
        .writeAddr  (dataChannel),
        .writeData  (dataBinary),
        .readAddr   (scanIdx),
        .readData   (scanData)
    );

    // Output latches, copied while latch-load is low
    logic [WIDTH-1:0] next_dacCode [NCHAN];
    logic [WIDTH-1:0] next_commandValue;
    logic [MON_WIDTH-1:0] next_monitorReg;

    always_comb begin
        next_resetHold    = {resetHold[1:0], 1'b0};
        next_scanIdx      = scanIdx + 3'h1;
        next_dacCode      = dacCode;
        next_commandValue = commandValue;
        next_monitorReg   = monitorReg;
        if (resetPending) begin
            for (int i = 0; i < NCHAN; i++) begin
                next_dacCode[i] = resetCode;
            end
        end else if (latchLow) begin
            next_dacCode[scanIdxQ] = scanData;
        end
        if (commandWrite) begin
            next_commandValue = commandWord;
        end
        if (monitorWrite) begin
            next_monitorReg = monitorWord;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resetHold    <= 3'h7;
            scanIdx      <= '0;
            scanIdxQ     <= '0;
            for (int i = 0; i < NCHAN; i++) begin
                dacCode[i] <= '0;
            end
            commandValue <= '0;
            monitorReg   <= MON_HIGH_Z;
        end else begin
            resetHold    <= next_resetHold;
            scanIdx      <= next_scanIdx;
            scanIdxQ     <= scanIdx;
            dacCode      <= next_dacCode;
            commandValue <= next_commandValue;
            monitorReg   <= next_monitorReg;
        end
    end

    // Output switches per channel, all eight set by the same clear and latch levels
    genvar g;
    generate
        for (g = 0; g < NCHAN; g++) begin : gSwitch
            always_comb begin
                outputGrounded[g] = clearLow;
                outputDriven[g]   = !clearLow && latchLow;
            end
        end
    endgenerate
    assign groupOffsetSel = 2'b10;

    // Correction engine: runs a fixed time after each data write
    eng_state_t engState;
    eng_state_t next_engState;
    logic [2:0] engCount;
    logic [2:0] next_engCount;

    always_comb begin
        next_engState = engState;
        next_engCount = engCount;
        case (engState)
            ENG_IDLE: begin
                if (dataWrite) begin
                    next_engState = ENG_RUN;
                    next_engCount = 3'(CORR_CYCLES - 1);
                end
            end
            ENG_RUN: begin
                // A new write restarts the full correction time
                if (dataWrite) begin
                    next_engCount = 3'(CORR_CYCLES - 1);
                end else if (engCount == 3'h0) begin
                    next_engState = ENG_IDLE;
                end else begin
                    next_engCount = engCount - 3'h1;
                end
            end
            default: begin
                next_engState = ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            engState <= ENG_IDLE;
            engCount <= '0;
        end else begin
            engState <= next_engState;
            engCount <= next_engCount;
        end
    end

    // Open drain: never drives high, enable low pulls the pin down
    assign busyOut  = 1'b0;
    assign busyOe_b = (engState != ENG_RUN);

    // Monitor decode: one source at most
    always_comb begin
        monitorEnable  = 1'b1;
        monitorSource  = MSRC_NONE;
        monitorChannel = monitorReg[CHAN_BITS-1:0];
        monitorGroupB  = monitorReg[0];
        if (monitorReg[4]) begin
            monitorSource = MSRC_CHAN;
            monitorGroupB = monitorReg[2];
        end else if (monitorReg == MON_REF_A || monitorReg == MON_REF_B) begin
            monitorSource = MSRC_REF;
        end else if (monitorReg == MON_OFS_A || monitorReg == MON_OFS_B) begin
            monitorSource = MSRC_OFS;
        end else begin
            monitorEnable = 1'b0;
        end
    end
endmodule : octal_dac_pin_control
`default_nettype wire

// >>> verif/octal_dac_pin_control_props.sv
// Concurrent checks on the pin control ports.
// Bound onto octal_dac_pin_control from the bench; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module octal_dac_pin_control_props
    import octal_dac_pkg::*;
#(
    parameter int NCHAN = CHANNELS,
    parameter int WIDTH = CODE_WIDTH
) (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 clear_outputs_n,
    input wire logic                 latch_load_n,
    input wire logic                 dataWrite,
    input wire logic                 commandWrite,
    input wire logic [WIDTH-1:0]     commandWord,
    input wire logic                 monitorWrite,
    input wire logic [MON_WIDTH-1:0] monitorWord,
    input wire logic [NCHAN-1:0]     outputGrounded,
    input wire logic [NCHAN-1:0]     outputDriven,
    input wire logic                 busyOe_b,
    input wire logic [WIDTH-1:0]     commandValue,
    input wire logic [MON_WIDTH-1:0] monitorReg,
    input wire logic                 monitorEnable,
    input wire mon_src_t             monitorSource,
    input wire logic [CHAN_BITS-1:0] monitorChannel,
    input wire logic                 monitorGroupB
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_cmd_raw: assert property (commandWrite |=> commandValue == $past(commandWord))
        else $error("command value differs from word written");
    a_busy_hold: assert property (dataWrite |=> !busyOe_b [*4])
        else $error("busy not held after data write");
    a_busy_release: assert property ($rose(busyOe_b) |-> $past(dataWrite, 5) && !$past(dataWrite))
        else $error("busy released at wrong time");
    a_clear_ground: assert property (!clear_outputs_n [*4] |-> &outputGrounded && outputDriven == '0)
        else $error("outputs not grounded while clear low");
    a_drive_on: assert property ((clear_outputs_n && !latch_load_n) [*4] |-> &outputDriven)
        else $error("outputs not driven by amplifiers");
    a_never_both: assert property ((outputGrounded & outputDriven) == '0)
        else $error("channel grounded and driven at once");
    a_mon_write: assert property (monitorWrite |=> monitorReg == $past(monitorWord))
        else $error("monitor register not loaded");
    a_mon_hiz: assert property (monitorReg == MON_HIGH_Z |-> !monitorEnable)
        else $error("monitor enabled for high-Z code");
    a_mon_chan: assert property (monitorReg[4:3] == 2'b10 |-> monitorEnable
        && monitorSource == MSRC_CHAN && monitorChannel == monitorReg[2:0])
        else $error("monitor channel decode wrong");
    a_group_split: assert property (monitorSource == MSRC_CHAN |-> monitorGroupB == monitorChannel[2])
        else $error("channel group wrong");
endmodule : octal_dac_pin_control_props
`default_nettype wire

// >>> verif/busy_pullup.sv
// Board side of the open-drain busy pin: the pullup the host reads through.
// Assumes busyOe_b low means the device sinks the pin.
`timescale 1ns/1ps
`default_nettype none
module busy_pullup (
    input  wire logic busyOut,
    input  wire logic busyOe_b,
    output var  logic busyPin
);
    // Released pin floats up, never keeps the last driven level
    assign busyPin = busyOe_b ? 1'b1 : busyOut;
endmodule : busy_pullup
`default_nettype wire

// >>> verif/test_octal_dac_pin_control.sv
// Self-checking bench for octal_dac_pin_control with a busy pullup model.
// Assumes pin inputs need two edges to pass the synchronisers.
`timescale 1ns/1ps
`default_nettype none
module test_octal_dac_pin_control;
    import octal_dac_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, fmt = 1'b0, clr_n = 1'b1, ld_n = 1'b0, rsel = 1'b1;
    logic dataWrite = 1'b0, commandWrite = 1'b0, monitorWrite = 1'b0, busyOut, busyOe_b, busyPin;
    logic [2:0] dataChannel = 3'h0;
    logic [13:0] dataWord = 14'h0000, commandWord = 14'h0000, commandValue, e [8];
    logic [4:0] monitorWord = 5'h00, monitorReg, m, tbl [6];
    logic [13:0] dacCode [8];
    logic [7:0] outputGrounded, outputDriven;
    logic monitorEnable, monitorGroupB;
    logic [2:0] monitorChannel;
    logic [1:0] groupOffsetSel;
    mon_src_t monitorSource;
    int seed = 32'h81d5, error_cnt = 0, checks_done = 0;
    always #10 clk = ~clk;
    octal_dac_pin_control u_octal_dac_pin_control (.clk(clk), .rst_b(rst_b),
        .data_format_select(fmt), .clear_outputs_n(clr_n), .latch_load_n(ld_n),
        .reset_value_select(rsel), .dataWrite(dataWrite), .dataChannel(dataChannel),
        .dataWord(dataWord), .commandWrite(commandWrite), .commandWord(commandWord),
        .monitorWrite(monitorWrite), .monitorWord(monitorWord), .dacCode(dacCode),
        .outputGrounded(outputGrounded), .outputDriven(outputDriven),
        .groupOffsetSel(groupOffsetSel),
        .busyOut(busyOut), .busyOe_b(busyOe_b), .commandValue(commandValue),
        .monitorReg(monitorReg), .monitorEnable(monitorEnable), .monitorSource(monitorSource),
        .monitorChannel(monitorChannel), .monitorGroupB(monitorGroupB));
    busy_pullup u_busy_pullup (.busyOut(busyOut), .busyOe_b(busyOe_b), .busyPin(busyPin));
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    function automatic logic [13:0] exp_code(logic [13:0] w, logic f);
        return f ? w ^ SIGN_FLIP : w;
    endfunction : exp_code
    task automatic rst_check(logic [13:0] v);
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        tick(3);
        for (int c = 0; c < 8; c++) check(dacCode[c], v);
    endtask : rst_check
    initial begin
        #(20ns * 20000);
        error_cnt++;
        wrap_up();
    end
    initial begin
        tbl = '{MON_REF_A, MON_REF_B, MON_OFS_A, MON_OFS_B, MON_HIGH_Z, 5'h0C};
        tick(20);
        rst_b = 1'b1;
        tick(3);
        rst_check(RESET_MID);
        check(groupOffsetSel, 2'h2);
        for (int r = 0; r < 4; r++) begin
            fmt = r[0];
            tick(3);
            // Back to back writes, first round at code extremes
            for (int c = 0; c < 8; c++) begin
                dataChannel = c[2:0];
                dataWord = (r == 0) ? {14{c[0]}} : 14'($random(seed));
                e[c] = exp_code(dataWord, fmt);
                dataWrite = 1'b1;
                tick(1);
            end
            dataWrite = 1'b0;
            check(busyPin, 1'b0);
            commandWord = 14'($random(seed));
            commandWrite = 1'b1;
            tick(1);
            commandWrite = 1'b0;
            check(commandValue, commandWord);
            tick(12);
            check(busyPin, 1'b1);
            for (int c = 0; c < 8; c++) check(dacCode[c], e[c]);
        end
        ld_n = 1'b1;
        tick(3);
        check(outputDriven, 8'h00);
        dataChannel = 3'h5;
        dataWord = 14'($random(seed));
        dataWrite = 1'b1;
        tick(1);
        dataWrite = 1'b0;
        tick(12);
        check(dacCode[5], e[5]);
        ld_n = 1'b0;
        tick(14);
        check(dacCode[5], exp_code(dataWord, fmt));
        check(outputDriven, 8'hFF);
        check(outputGrounded, 8'h00);
        clr_n = 1'b0;
        tick(4);
        check(outputGrounded, 8'hFF);
        check(outputDriven, 8'h00);
        clr_n = 1'b1;
        for (int i = 0; i < 14; i++) begin
            m = (i < 8) ? MON_CHAN_BASE + 5'(i) : tbl[i-8];
            monitorWord = m;
            monitorWrite = 1'b1;
            tick(1);
            monitorWrite = 1'b0;
            check(monitorEnable, i < 12);
            if (i < 12) check({monitorSource, monitorGroupB}, {(i < 8) ? MSRC_CHAN
                : (i < 10) ? MSRC_REF : MSRC_OFS, (i < 8) ? i[2] : i[0]});
            if (i < 8) check(monitorChannel, i[2:0]);
            tick(1);
        end
        rsel = 1'b0;
        tick(3);
        rst_check(RESET_ZERO);
        wrap_up();
    end
endmodule : test_octal_dac_pin_control
bind octal_dac_pin_control octal_dac_pin_control_props #(.NCHAN(NCHAN), .WIDTH(WIDTH)) u_props (
    .clk(clk), .rst_b(rst_b), .clear_outputs_n(clear_outputs_n), .latch_load_n(latch_load_n),
    .dataWrite(dataWrite), .commandWrite(commandWrite), .commandWord(commandWord),
    .monitorWrite(monitorWrite), .monitorWord(monitorWord), .outputGrounded(outputGrounded),
    .outputDriven(outputDriven), .busyOe_b(busyOe_b), .commandValue(commandValue),
    .monitorReg(monitorReg), .monitorEnable(monitorEnable), .monitorSource(monitorSource),
    .monitorChannel(monitorChannel), .monitorGroupB(monitorGroupB));
`default_nettype wire
